// ===== hdl/rssm_top.sv
// reset sequencer with supply integrity supervision and axi4-lite registers
`timescale 1ns/100ps
module rssm_top
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   rst_pin_in,
	output logic                        rst_pin_out,
	output logic                        rst_pin_oe,
	input  wire logic                   low_voltage_detector_below,
	input  wire logic                   aux_voltage_detector_below,
	input  wire logic                   watchdog_underflow,
	input  wire logic                   illegal_opcode,
	input  wire logic                   pll_locked,
	output logic                        low_voltage_detector_en,
	output logic [1:0]                  low_voltage_detector_thr,
	output logic                        undervoltage_use_rise,
	output logic [2:0]                  multi_oscillator_sel,
	output logic                        multi_oscillator_keep_run,
	output logic                        default_ext_clock_port_pin,
	output logic                        pll_en,
	output logic                        cpu_clk_avail,
	output rssm_pkg::rssm_vec_req_t     vec_req,
	input  wire logic [7:0]             vec_rdata,
	output logic                        pc_load,
	output logic [15:0]                 pc_value,
	output logic                        core_rst_n,
	output logic                        supply_warning_irq,
	input  wire logic                   supply_warning_irq_ack
);
	import rssm_pkg::*;

	rssm_state_t        state_r;
	rssm_opt_t          opt_r;
	logic [CNT_W-1:0]   cnt_r;
	logic [CNT_W-1:0]   delay_len;
	logic [CNT_W-1:0]   pulse_r;
	logic               ext_latch_r;
	logic [1:0]         ext_sync_r;
	logic [1:0]         lvd_sync_r;
	logic [1:0]         avd_sync_r;
	logic               ext_cause;
	logic               lvd_cause;
	logic               soft_cause;
	logic               any_cause;
	logic               warn_flag;
	logic               warn_prev_r;
	logic               irq_en_r;
	logic               irq_pend_r;
	logic               wdg_flag_r;
	logic               uv_flag_r;
	logic               xtal_sel;
	logic [7:0]         vec_hi_r;
	logic               aw_full_r;
	logic               w_full_r;
	logic [7:0]         aw_addr_r;
	logic [31:0]        w_data_r;
	logic [3:0]         w_strb_r;
	logic               wr_go;
	logic               rd_go;
	logic               ics_rd;
	logic               ics_wr;
	logic               opt_wr;

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == ADDR_ICS) || (a == ADDR_OPT) || (a == ADDR_SEQ);
	endfunction : reg_hit

	// pin capture: set with no clock so a halted device still sees it
	always_ff @(posedge aclk or negedge rst_pin_in)
	begin
		if (!rst_pin_in)
			ext_latch_r <= 1'b1;
		else if (!aresetn || state_r != ST_RUN)
			ext_latch_r <= 1'b0;
	end

	// two-stage synchronisers for the pin capture and both voltage detectors
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_sync_r <= 2'h0;
			lvd_sync_r <= 2'h0;
			avd_sync_r <= 2'h0;
		end
		else
		begin
			// flushed outside run so a stale capture of our own drive
			// cannot restart the sequence right after the fetch
			if (state_r != ST_RUN)
				ext_sync_r <= 2'h0;
			else
				ext_sync_r <= {ext_sync_r[0], ext_latch_r};
			lvd_sync_r <= {lvd_sync_r[0], low_voltage_detector_below};
			avd_sync_r <= {avd_sync_r[0], aux_voltage_detector_below};
		end
	end

	// own drive of the pin reads back as low, so the pin counts only
	// while running; short glitches are held by the latch
	assign ext_cause  = ext_sync_r[1] && state_r == ST_RUN;
	assign lvd_cause  = lvd_sync_r[1] && opt_r.lvd_en;
	assign soft_cause = watchdog_underflow || illegal_opcode;
	assign any_cause  = ext_cause || lvd_cause || soft_cause;

	assign xtal_sel = opt_r.clk_src >= SRC_XTAL_MIN &&
		opt_r.clk_src <= SRC_XTAL_MAX;
	assign delay_len = xtal_sel ? CNT_W'(DLY_LONG_CYC) :
		CNT_W'(DLY_SHORT_CYC);

	// sequence: active, delay, optional multiplier wait, fetch, run
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= ST_ACTIVE;
			cnt_r   <= '0;
			pulse_r <= CNT_W'(MIN_RST_OUT_CYC);
		end
		else if (any_cause)
		begin
			state_r <= ST_ACTIVE;
			cnt_r   <= '0;
			if (soft_cause)
				pulse_r <= CNT_W'(MIN_RST_OUT_CYC);
		end
		else
		begin
			unique case (state_r)
				ST_ACTIVE:
				begin
					if (pulse_r != '0)
						pulse_r <= pulse_r - CNT_W'(1);
					else
					begin
						state_r <= ST_DELAY;
						cnt_r   <= '0;
					end
				end
				ST_DELAY:
				begin
					if (cnt_r == delay_len - CNT_W'(1))
					begin
						cnt_r   <= '0;
						state_r <= opt_r.pll_en ? ST_PLL : ST_FETCH;
					end
					else
						cnt_r <= cnt_r + CNT_W'(1);
				end
				ST_PLL:
				begin
					if (cnt_r == CNT_W'(PLL_STARTUP_CYC - 1))
					begin
						cnt_r   <= '0;
						state_r <= ST_FETCH;
					end
					else
						cnt_r <= cnt_r + CNT_W'(1);
				end
				ST_FETCH:
				begin
					if (cnt_r == CNT_W'(FETCH_CYC - 1))
					begin
						cnt_r   <= '0;
						state_r <= ST_RUN;
					end
					else
						cnt_r <= cnt_r + CNT_W'(1);
				end
				ST_RUN:
					cnt_r <= '0;
			endcase
		end
	end

	// pin held low through active and delay phases only
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe  = state_r == ST_ACTIVE ||
		state_r == ST_DELAY;

	// clock comes up only after the multiplier has settled
	assign cpu_clk_avail = state_r == ST_FETCH ||
		state_r == ST_RUN;

	// vector fetch, high byte at the lower address
	always_comb
	begin
		vec_req.rd   = state_r == ST_FETCH;
		vec_req.addr = (cnt_r == '0) ? VEC_HI_ADDR : VEC_LO_ADDR;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			vec_hi_r   <= 8'h00;
			pc_value   <= 16'h0000;
			pc_load    <= 1'b0;
			core_rst_n <= 1'b0;
		end
		else
		begin
			pc_load <= 1'b0;
			if (state_r == ST_FETCH && cnt_r == '0 && !any_cause)
				vec_hi_r <= vec_rdata;
			if (state_r == ST_FETCH && cnt_r != '0 && !any_cause)
			begin
				pc_value <= {vec_hi_r, vec_rdata};
				pc_load  <= 1'b1;
			end
			// released two cycles after the last fetch cycle, one cycle after pc_load
			core_rst_n <= state_r == ST_RUN && !any_cause;
		end
	end

	// option outputs to analog and oscillator blocks
	assign low_voltage_detector_en  = opt_r.lvd_en;
	assign low_voltage_detector_thr = opt_r.lvd_thr;
	// in static reset the rising threshold applies, giving hysteresis
	assign undervoltage_use_rise = lvd_cause || state_r != ST_RUN;
	assign multi_oscillator_sel  = opt_r.clk_src;
	assign default_ext_clock_port_pin =
		opt_r.clk_src == SRC_PORT_PIN;
	// keeping the resonator alive while a crystal is selected; each reset still waits the long delay
	assign multi_oscillator_keep_run = xtal_sel;
	assign pll_en = opt_r.pll_en;

	// live comparator level, meaningless without the detector
	assign warn_flag = avd_sync_r[1] && opt_r.lvd_en;

	// register bus: write address and data may arrive in either order
	assign s_axi_awready = !aw_full_r;
	assign s_axi_wready  = !w_full_r;
	assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign ics_rd = rd_go && s_axi_araddr == ADDR_ICS;
	assign ics_wr = wr_go && aw_addr_r == ADDR_ICS && w_strb_r[0];
	assign opt_wr = wr_go && aw_addr_r == ADDR_OPT && w_strb_r[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_r    <= 1'b0;
			w_full_r     <= 1'b0;
			aw_addr_r    <= 8'h00;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_r)
			begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_r)
			begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= reg_hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			s_axi_rdata  <= 32'h0000_0000;
			if (s_axi_araddr == ADDR_ICS)
			begin
				s_axi_rdata[ICS_IRQ_EN]  <= irq_en_r;
				s_axi_rdata[ICS_WARN]    <= warn_flag;
				s_axi_rdata[ICS_UV_FLAG] <= uv_flag_r;
				s_axi_rdata[ICS_LOCKED]  <= pll_locked;
				s_axi_rdata[ICS_WDG]     <= wdg_flag_r;
			end
			else if (s_axi_araddr == ADDR_OPT)
				s_axi_rdata[6:0] <= opt_r;
			else if (s_axi_araddr == ADDR_SEQ)
			begin
				s_axi_rdata[SEQ_STATE_LSB +: 3] <= state_r;
				s_axi_rdata[SEQ_PIN_DRV]        <= rst_pin_oe;
				s_axi_rdata[SEQ_CORE_RST]       <= !core_rst_n;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// option field and interrupt enable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			opt_r    <= OPT_RST;
			irq_en_r <= 1'b0;
		end
		else
		begin
			if (opt_wr)
				opt_r <= w_data_r[6:0];
			if (ics_wr)
				irq_en_r <= w_data_r[ICS_IRQ_EN];
		end
	end

	// cause flags: setting beats a software clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wdg_flag_r <= 1'b0;
			uv_flag_r  <= 1'b0;
		end
		else
		begin
			if (lvd_cause)
				wdg_flag_r <= 1'b0;
			else if (watchdog_underflow)
				wdg_flag_r <= 1'b1;
			else if (ics_wr && !w_data_r[ICS_WDG])
				wdg_flag_r <= 1'b0;
			if (lvd_cause)
				uv_flag_r <= 1'b1;
			else if (ics_rd)
				uv_flag_r <= 1'b0;
		end
	end

	// warning interrupt: pending on the flag's rising edge until acked or disabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			warn_prev_r <= 1'b0;
			irq_pend_r  <= 1'b0;
		end
		else
		begin
			warn_prev_r <= warn_flag;
			if (warn_flag && !warn_prev_r && irq_en_r)
				irq_pend_r <= 1'b1;
			else if (supply_warning_irq_ack || !irq_en_r)
				irq_pend_r <= 1'b0;
		end
	end

	assign supply_warning_irq = irq_pend_r;

endmodule : rssm_top

// ===== hdl/rssm_pkg.sv
// constants, field layouts and types of the reset sequencer and supply monitor
package rssm_pkg;

	// clock period in picoseconds (250 MHz)
	localparam int CLK_PERIOD_PS = 4000;

	// times in their own units, counts derived from them
	localparam int MIN_RST_OUT_NS  = 1000;
	localparam int MIN_RST_OUT_CYC =
		(MIN_RST_OUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PLL_STARTUP_NS  = 2000;
	localparam int PLL_STARTUP_CYC =
		(PLL_STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// stabilisation delays in cpu clocks, vector fetch length
	localparam int DLY_SHORT_CYC = 256;
	localparam int DLY_LONG_CYC  = 4096;
	localparam int FETCH_CYC     = 2;
	localparam int CNT_W         = 13;

	// reset vector location (high byte first)
	localparam logic [15:0] VEC_HI_ADDR = 16'hfffe;
	localparam logic [15:0] VEC_LO_ADDR = 16'hffff;

	// register byte offsets
	localparam logic [7:0] ADDR_ICS = 8'h00;
	localparam logic [7:0] ADDR_OPT = 8'h04;
	localparam logic [7:0] ADDR_SEQ = 8'h08;

	// integrity_ctrl_status fields
	localparam int ICS_IRQ_EN  = 0;
	localparam int ICS_WARN    = 1;
	localparam int ICS_UV_FLAG = 2;
	localparam int ICS_LOCKED  = 3;
	localparam int ICS_WDG     = 4;

	// seq_status fields
	localparam int SEQ_STATE_LSB = 0;
	localparam int SEQ_PIN_DRV   = 3;
	localparam int SEQ_CORE_RST  = 4;

	// clock source encodings of the option field
	localparam logic [2:0] SRC_EXT_OSC_IN = 3'h0;
	localparam logic [2:0] SRC_XTAL_MIN   = 3'h1;
	localparam logic [2:0] SRC_XTAL_MAX   = 3'h4;
	localparam logic [2:0] SRC_RC         = 3'h5;
	localparam logic [2:0] SRC_PORT_PIN   = 3'h6;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       pll_en;
		logic [1:0] lvd_thr;
		logic       lvd_en;
		logic [2:0] clk_src;
	} rssm_opt_t;

	localparam rssm_opt_t OPT_RST = 7'h06;

	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} rssm_vec_req_t;

	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_DELAY,
		ST_PLL,
		ST_FETCH,
		ST_RUN
	} rssm_state_t;

endpackage : rssm_pkg

// ===== test/rssm_assertions.sv
// concurrent checks on the ports of the reset sequencer
`timescale 1ns/100ps
module rssm_assertions
	import rssm_pkg::*;
(
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic                    rst_pin_out,
	input wire logic                    rst_pin_oe,
	input wire logic                    low_voltage_detector_below,
	input wire logic                    low_voltage_detector_en,
	input wire logic                    watchdog_underflow,
	input wire logic                    illegal_opcode,
	input wire logic [2:0]              multi_oscillator_sel,
	input wire logic                    multi_oscillator_keep_run,
	input wire logic                    default_ext_clock_port_pin,
	input wire rssm_pkg::rssm_vec_req_t vec_req,
	input wire logic [7:0]              vec_rdata,
	input wire logic                    pc_load,
	input wire logic [15:0]             pc_value,
	input wire logic                    core_rst_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence lo_fetch;
		vec_req.rd && vec_req.addr == VEC_LO_ADDR;
	endsequence

	a_fetch_order: assert property ($rose(vec_req.rd) |->
		(vec_req.addr == VEC_HI_ADDR) ##1 lo_fetch)
		else $error("vector fetch order wrong");
	a_fetch_len: assert property (vec_req.rd [*2] |=> !vec_req.rd)
		else $error("vector fetch longer than two cycles");
	a_pc_load: assert property (lo_fetch |=> pc_load)
		else $error("no pc load after fetch");
	a_pc_value: assert property (lo_fetch |=>
		pc_value == {$past(vec_rdata, 2), $past(vec_rdata)})
		else $error("pc value not from vector");
	a_pin_od: assert property (rst_pin_oe |-> !rst_pin_out)
		else $error("reset pin driven high");
	a_wdg_pin: assert property (watchdog_underflow |=> rst_pin_oe [*8])
		else $error("watchdog reset pin pulse short");
	a_bad_op: assert property (illegal_opcode |=>
		rst_pin_oe ##1 !core_rst_n)
		else $error("illegal opcode did not reset");
	a_lvd_hold: assert property (
		(low_voltage_detector_below && low_voltage_detector_en) [*5]
		|-> rst_pin_oe && !core_rst_n)
		else $error("undervoltage not held in reset");
	a_osc_keep: assert property (multi_oscillator_keep_run ==
		(multi_oscillator_sel >= 3'h1 && multi_oscillator_sel <= 3'h4))
		else $error("resonator keep running wrong");
	a_port_pin: assert property (default_ext_clock_port_pin ==
		(multi_oscillator_sel == SRC_PORT_PIN))
		else $error("default clock pin select wrong");

	c_fetch: cover property (lo_fetch ##1 pc_load);
	c_wdg: cover property (watchdog_underflow);
	c_lvd: cover property (low_voltage_detector_below && rst_pin_oe);
endmodule : rssm_assertions

bind rssm_top rssm_assertions u_chk (.aclk, .aresetn, .rst_pin_out,
	.rst_pin_oe, .low_voltage_detector_below, .low_voltage_detector_en,
	.watchdog_underflow, .illegal_opcode, .multi_oscillator_sel,
	.multi_oscillator_keep_run, .default_ext_clock_port_pin, .vec_req,
	.vec_rdata, .pc_load, .pc_value, .core_rst_n);

// ===== test/rssm_pin_model.sv
// external reset circuit on the shared open-drain reset line
`timescale 1ns/100ps
module rssm_pin_model
#(
	parameter int MIN_W = 8
)
(
	input wire logic aclk,
	input wire logic pull_req,
	input wire logic oe,
	output logic     pin
);
	int cnt;

	// a request is stretched so a short one is never too narrow
	always @(posedge aclk)
		if (pull_req)
			cnt <= MIN_W;
		else if (cnt > 0)
			cnt <= cnt - 1;

	// weak pull-up: high unless someone pulls low
	assign pin = !(oe || cnt > 0);
endmodule : rssm_pin_model

// ===== test/rssm_top_test.sv
// self-checking bench for the reset sequencer and supply monitor
`timescale 1ns/100ps
module rssm_top_test;
	import rssm_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, rst_pin_in;
	logic rst_pin_out, rst_pin_oe, low_voltage_detector_below;
	logic aux_voltage_detector_below, watchdog_underflow, illegal_opcode;
	logic pll_locked, low_voltage_detector_en, undervoltage_use_rise;
	logic multi_oscillator_keep_run, default_ext_clock_port_pin, pll_en;
	logic cpu_clk_avail, pc_load, core_rst_n, supply_warning_irq;
	logic supply_warning_irq_ack, pull_req;
	logic [7:0]    s_axi_awaddr, s_axi_araddr, vec_rdata;
	logic [31:0]   s_axi_wdata, s_axi_rdata, d;
	logic [3:0]    s_axi_wstrb;
	logic [1:0]    s_axi_bresp, s_axi_rresp, low_voltage_detector_thr, r, b;
	logic [2:0]    multi_oscillator_sel;
	logic [15:0]   pc_value;
	rssm_vec_req_t vec_req;
	int            bad_count, cmp_count, t0, n0, t1, n1, t2, n2, t3, n3;

	rssm_top dut (.*);
	rssm_pin_model u_pin (.aclk(aclk), .pull_req(pull_req),
		.oe(rst_pin_oe), .pin(rst_pin_in));
	assign vec_rdata = vec_req.addr[0] ? 8'h34 : 8'h12;

	initial
	begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end

	task close_out;
		$display("checks %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task hang;
		bad_count++;
		close_out();
	endtask : hang

	task wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		b = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 50)
			hang();
	endtask : wr

	task rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 50)
			hang();
	endtask : rd

	// t counts cycles to the pc load, n those with the device driving the pin low (rst_pin_oe)
	task run_seq(output int t, output int n);
		n = 0;
		for (t = 0; t < 9000; t++)
		begin
			@(posedge aclk);
			if (rst_pin_oe)
				n++;
			if (pc_load)
				break;
		end
		if (t == 9000)
			hang();
	endtask : run_seq

	task pulse(input int k);
		@(posedge aclk);
		watchdog_underflow <= (k == 0);
		illegal_opcode <= (k == 1);
		pull_req <= (k == 2);
		supply_warning_irq_ack <= (k == 3);
		@(posedge aclk);
		{watchdog_underflow, illegal_opcode} <= 2'h0;
		{pull_req, supply_warning_irq_ack} <= 2'h0;
	endtask : pulse

	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, pull_req, illegal_opcode} = 4'h0;
		{watchdog_underflow, supply_warning_irq_ack} = 2'h0;
		{low_voltage_detector_below, aux_voltage_detector_below} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		pll_locked = 1'b1;
		{bad_count, cmp_count} = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		run_seq(t0, n0);
		chk("pc", 32'h1234, 32'(pc_value));
		chk("clk", 1, 32'(cpu_clk_avail));
		chk("rise", 0, 32'(undervoltage_use_rise));
		rd(ADDR_OPT);
		chk("opt", 32'(OPT_RST), d);
		rd(8'h0c);
		chk("resp", 32'(RESP_SLVERR), 32'(r));
		wr(8'h0c, 32'h0);
		chk("bresp", 32'(RESP_SLVERR), 32'(b));
		pulse(0);
		run_seq(t1, n1);
		chk("wdlen", 1, MIN_RST_OUT_CYC + DLY_SHORT_CYC <= n1);
		rd(ADDR_ICS);
		chk("wdgf", 1, 32'(d[ICS_WDG]));
		wr(ADDR_ICS, 32'h0);
		rd(ADDR_ICS);
		chk("wdgc", 0, 32'(d[ICS_WDG]));
		wr(ADDR_OPT, 32'h1);
		chk("keep", 1, 32'(multi_oscillator_keep_run));
		pulse(0);
		run_seq(t2, n2);
		chk("long", DLY_LONG_CYC - DLY_SHORT_CYC, 32'(n2 - n1));
		pulse(1);
		run_seq(t3, n3);
		chk("bad", 32'(n2), 32'(n3));
		wr(ADDR_OPT, 32'h6d);
		chk("lvd", 32'h3, {pll_en, low_voltage_detector_en});
		chk("thr", 32'h2, 32'(low_voltage_detector_thr));
		pulse(1);
		run_seq(t0, n0);
		chk("pll", PLL_STARTUP_CYC, 32'((t0 - n0) - (t3 - n3)));
		low_voltage_detector_below <= 1'b1;
		repeat (600) @(posedge aclk);
		chk("lvpin", 1, 32'(rst_pin_oe));
		chk("lvcore", 0, 32'(core_rst_n));
		chk("lvclk", 0, 32'(cpu_clk_avail));
		chk("lvrise", 1, 32'(undervoltage_use_rise));
		low_voltage_detector_below <= 1'b0;
		run_seq(t0, n0);
		// the external reset must not wipe the undervoltage record
		pulse(2);
		run_seq(t0, n0);
		chk("extpin", 1, 32'(n0 > 0));
		rd(ADDR_ICS);
		chk("uvf", 1, 32'(d[ICS_UV_FLAG]));
		chk("wdglv", 0, 32'(d[ICS_WDG]));
		rd(ADDR_ICS);
		chk("uvrd", 0, 32'(d[ICS_UV_FLAG]));
		wr(ADDR_ICS, 32'h1);
		aux_voltage_detector_below <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(ADDR_ICS);
		chk("warn", 1, 32'(d[ICS_WARN]));
		chk("irq", 1, 32'(supply_warning_irq));
		pulse(3);
		@(posedge aclk);
		chk("irqack", 0, 32'(supply_warning_irq));
		wr(ADDR_OPT, 32'h05);
		rd(ADDR_ICS);
		chk("warnoff", 0, 32'(d[ICS_WARN]));
		aux_voltage_detector_below <= 1'b0;
		close_out();
	end
endmodule : rssm_top_test
